// ==== core/cutter_pkg.sv ====
// cutter status output package: register offsets, signal indices,
// field positions, reset values, run states and the motion input bundle
// assumes a single 20 MHz system clock and synchronous controller inputs
package cutter_pkg;

  // widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_SIG = 32;
  localparam int unsigned NUM_LINES = 8;
  localparam int unsigned ROUTE_W = 4;
  localparam int unsigned POS_W = 16;
  localparam int unsigned MISS_W = 8;
  localparam int unsigned SIG_PER_WORD = 8;
  localparam int unsigned NUM_ROUTE_REGS = 4;

  // register byte offsets
  localparam logic [7:0] REG_ROUTE0 = 8'h00;
  localparam logic [7:0] REG_ROUTE3 = 8'h0c;
  localparam logic [7:0] REG_ALARM = 8'h10;
  localparam logic [7:0] REG_HOME_WIN = 8'h14;
  localparam logic [7:0] REG_MISS = 8'h18;
  localparam logic [7:0] REG_LEN_FACTOR = 8'h1c;
  localparam logic [7:0] REG_CUT_TOL = 8'h20;
  localparam logic [7:0] REG_MASTER_ZERO = 8'h24;
  localparam logic [7:0] REG_VIRT_ZERO = 8'h28;
  localparam logic [7:0] REG_REV_LIMIT = 8'h2c;
  localparam logic [7:0] REG_MAX_CORR = 8'h30;
  localparam logic [7:0] REG_THICK_WIN = 8'h34;
  localparam logic [7:0] REG_CTRL = 8'h38;
  localparam logic [7:0] REG_CUT_WIN = 8'h3c;
  localparam logic [7:0] REG_CUT_OFS = 8'h40;
  localparam logic [7:0] REG_SIG_STAT = 8'h44;
  localparam logic [7:0] REG_LINE_STAT = 8'h48;

  // field positions: windows hold start in low half, end in high half
  localparam int unsigned WIN_START_LSB = 0;
  localparam int unsigned WIN_END_LSB = 16;
  localparam int unsigned CTRL_MARK_WIN_EN = 0;
  localparam int unsigned CTRL_THICK_EN = 1;
  localparam int unsigned CTRL_THICK_INV = 2;

  // reset values
  localparam logic [15:0] RST_CFG16 = 16'h0000;
  localparam logic [15:0] RST_LEN_FACTOR = 16'h0001;
  localparam logic [7:0] RST_MISS = 8'h00;
  localparam logic [2:0] RST_CTRL = 3'h0;

  // output signal indices
  localparam int unsigned SIG_READY = 0;
  localparam int unsigned SIG_ALARM = 1;
  localparam int unsigned SIG_HOME = 2;
  localparam int unsigned SIG_NO_MARK = 3;
  localparam int unsigned SIG_LENGTH = 4;
  localparam int unsigned SIG_WASTE = 5;
  localparam int unsigned SIG_ERROR = 7;
  localparam int unsigned SIG_MASTER_MOV = 8;
  localparam int unsigned SIG_VIRT_MOV = 10;
  localparam int unsigned SIG_MARK_WIN = 11;
  localparam int unsigned SIG_REVERSE = 12;
  localparam int unsigned SIG_MAX_CORR = 13;
  localparam int unsigned SIG_TAUGHT = 14;
  localparam int unsigned SIG_HOMED = 15;
  localparam int unsigned SIG_AUTO = 16;
  localparam int unsigned SIG_THICK = 17;
  localparam int unsigned SIG_VCUT = 18;

  // automatic run states, gray along idle -> run -> stopping
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_ON = 2'b01,
    RUN_STOP = 2'b11
  } run_e;

  // controller state bundle feeding the status logic
  typedef struct packed {
    logic init_done;          // power-up and initialization finished
    logic selftest_ok;        // self-test passed
    logic err_cond;           // operational error present
    logic signed [15:0] pos_err; // cutter position error vs profile
    logic [15:0] knife_pos;   // knife position within one turn
    logic sheet_end;          // pulse: one sheet passed
    logic mark_det;           // pulse: printmark detected
    logic mark_win_open;      // printmark acceptance window open
    logic line_step;          // pulse: one unit of line travel
    logic line_fwd;           // travel direction of line_step
    logic clear_error;        // clear-error input
    logic [15:0] master_speed; // measured speed on first encoder
    logic [15:0] virt_freq;   // virtual master output frequency
    logic signed [15:0] corr_val; // proportional correction value
    logic teach;              // pulse: teach input acted
    logic teach_ok;           // teach capture succeeded
    logic homing_done;        // pulse: homing cycle finished
    logic jog;                // jog in progress
    logic ctrl_enable;        // control enable input
    logic start_stop;         // start/stop input
    logic cut_done;           // pulse: a cut completed
    logic signed [15:0] cut_dev; // length deviation of that cut
    logic test_cut;           // that cut was a test-length cut
    logic still;              // cutter at standstill
  } motion_s;

endpackage

// ==== core/length_pulse_gen.sv ====
// length pulse divider: toggles its output every factor steps of line
// travel so high and low time span equal travel
// assumes step_i is a one-cycle pulse synchronous to clk_i
`timescale 1ns/1ps
module length_pulse_gen
  import cutter_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // travel and scaling
  input wire logic step_i,
  input wire logic [CNT_W-1:0] factor_i,
  // pulse train
  output logic pulse_o
);

  // whole state of the divider
  typedef struct packed {
    logic [CNT_W-1:0] cnt; // steps since last toggle
    logic lvl;             // current output level
  } lp_s;

  lp_s st_r;
  lp_s st_nxt;

  // count steps, toggle on the factor-th one; factor 0 acts as 1
  always_comb begin
    st_nxt = st_r;
    if (step_i) begin
      if (st_r.cnt + CNT_W'(1) >= factor_i) begin
        st_nxt.cnt = '0;
        st_nxt.lvl = ~st_r.lvl; // RULE_08
      end else begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pulse_o = st_r.lvl;

endmodule

// ==== core/cutter_status_out.sv ====
// cutter status outputs: derives 32 indexed status signals from the
// motion controller state and routes any of them to 8 output lines
// assumes synchronous inputs, one clock, plain register port
//
// Operation
// RULE_01 - any signal routable to one of eight lines
// RULE_02 - line high while its assigned signal active
// RULE_03 - all signals readable regardless of routing
// RULE_04 - ready only after init and passing self-test
// RULE_05 - alarm while position error magnitude exceeds limit
// RULE_06 - home high inside home window only
// RULE_07 - missing mark after configured sheets without mark
// RULE_08 - length pulses scaled to travel, 1:1 duty
// RULE_09 - waste cut on tolerance miss or test cut
// RULE_10 - error high on operational error
// RULE_11 - master motion above master standstill threshold
// RULE_12 - virtual motion above virtual standstill threshold
// RULE_13 - mark window open, or always when disabled
// RULE_14 - reverse set past limit, cleared forward/clear
// RULE_15 - correction limit while correction reaches maximum
// RULE_16 - taught after successful teach capture
// RULE_17 - homed set on homing, cleared on invalidation
// RULE_18 - auto run until cut done and standstill
// RULE_19 - thickness window per mode between start, end
// RULE_20 - virtual cut pulse from offset cut to sync end
// RULE_21 - unused signal indices always inactive
`timescale 1ns/1ps
module cutter_status_out
  import cutter_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // controller state
  input wire motion_s mot_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // status and physical lines
  output logic [NUM_SIG-1:0] sig_o,
  output logic [NUM_LINES-1:0] line_o
);

  // whole state of the block
  typedef struct packed {
    logic [NUM_SIG-1:0][ROUTE_W-1:0] route; // 0 unrouted, k routes to line k-1
    logic [POS_W-1:0] alarm_lim;   // position alarm limit
    logic [POS_W-1:0] home_start;  // home window start
    logic [POS_W-1:0] home_end;    // home window end
    logic [MISS_W-1:0] miss_lim;   // sheets without mark before alarm
    logic [POS_W-1:0] len_factor;  // steps per length half-period
    logic [POS_W-1:0] cut_tol;     // cut tolerance
    logic [POS_W-1:0] master_zero; // master standstill speed
    logic [POS_W-1:0] virt_zero;   // virtual standstill frequency
    logic [POS_W-1:0] rev_lim;     // reverse travel limit
    logic [POS_W-1:0] max_corr;    // maximum correction
    logic [POS_W-1:0] thick_start; // thickness window start
    logic [POS_W-1:0] thick_end;   // thickness window end
    logic [2:0] ctrl;              // mode bits
    logic [POS_W-1:0] cut_pos;     // cutting position
    logic [POS_W-1:0] sync_end;    // end of sync zone after cut
    logic [POS_W-1:0] cut_ofs;     // cut pulse offset
    logic [MISS_W-1:0] miss_cnt;   // consecutive sheets without mark
    logic mark_seen;               // valid mark in current sheet
    logic [POS_W:0] rev_dist;      // reverse travel not yet undone
    logic rev_flag;                // reverse monitor
    logic taught;                  // mark taught
    logic homed;                   // homing complete
    logic waste;                   // last cut was waste
    logic cut_seen;                // cut finished while stopping
    run_e run;                     // automatic run state
    logic [NUM_SIG-1:0] sig;       // registered status signals
    logic [NUM_LINES-1:0] lines;   // registered physical lines
    logic [DATA_W-1:0] rdata;      // read data
  } st_s;

  st_s st_r;
  st_s st_nxt;

  logic len_pulse;               // length pulse level from divider
  logic [NUM_LINES-1:0] line_hit; // per line, any assigned signal active

  // magnitude of a signed 16-bit value, widened to avoid overflow
  function automatic logic [POS_W:0] mag(input logic signed [POS_W-1:0] v);
    logic [POS_W:0] ext;
    ext = {v[POS_W-1], v};
    mag = v[POS_W-1] ? (~ext + 17'h00001) : ext;
  endfunction

  // position inside a window that may wrap past the top of the turn
  function automatic logic in_win(input logic [POS_W-1:0] p,
                                  input logic [POS_W-1:0] s,
                                  input logic [POS_W-1:0] e);
    if (s <= e) begin
      in_win = (p >= s) && (p <= e);
    end else begin
      in_win = (p >= s) || (p <= e);
    end
  endfunction

  // length pulse divider
  length_pulse_gen #(
    .CNT_W(POS_W)
  ) u_len (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .step_i(mot_i.line_step),
    .factor_i(st_r.len_factor),
    .pulse_o(len_pulse)
  );

  // per line: or of every signal whose route selects this line
  for (genvar k = 0; k < NUM_LINES; k++) begin : g_line
    logic hit;
    always_comb begin
      hit = 1'b0;
      for (int j = 0; j < NUM_SIG; j++) begin
        if (st_r.route[j] == ROUTE_W'(k + 1) && st_r.sig[j]) begin
          hit = 1'b1; // RULE_01
        end
      end
    end
    assign line_hit[k] = hit;
  end

  // next-state logic: registers, supervision, status vector
  always_comb begin
    logic [POS_W-1:0] cut_at;
    logic [NUM_SIG-1:0] s;
    cut_at = '0;
    s = '0; // RULE_21
    st_nxt = st_r;

    // register writes
    if (wr_i) begin
      if (addr_i <= REG_ROUTE3 && addr_i[1:0] == 2'b00) begin
        // route words: eight nibbles per word
        for (int n = 0; n < SIG_PER_WORD; n++) begin
          st_nxt.route[32'(addr_i[3:2]) * SIG_PER_WORD + n] =
            wdata_i[n*ROUTE_W +: ROUTE_W]; // RULE_01
        end
      end
      case (addr_i)
        REG_ALARM: st_nxt.alarm_lim = wdata_i[POS_W-1:0];
        REG_HOME_WIN: begin
          st_nxt.home_start = wdata_i[WIN_START_LSB +: POS_W];
          st_nxt.home_end = wdata_i[WIN_END_LSB +: POS_W];
        end
        REG_MISS: st_nxt.miss_lim = wdata_i[MISS_W-1:0];
        REG_LEN_FACTOR: st_nxt.len_factor = wdata_i[POS_W-1:0];
        REG_CUT_TOL: st_nxt.cut_tol = wdata_i[POS_W-1:0];
        REG_MASTER_ZERO: st_nxt.master_zero = wdata_i[POS_W-1:0];
        REG_VIRT_ZERO: st_nxt.virt_zero = wdata_i[POS_W-1:0];
        REG_REV_LIMIT: st_nxt.rev_lim = wdata_i[POS_W-1:0];
        REG_MAX_CORR: st_nxt.max_corr = wdata_i[POS_W-1:0];
        REG_THICK_WIN: begin
          st_nxt.thick_start = wdata_i[WIN_START_LSB +: POS_W];
          st_nxt.thick_end = wdata_i[WIN_END_LSB +: POS_W];
        end
        REG_CTRL: st_nxt.ctrl = wdata_i[2:0];
        REG_CUT_WIN: begin
          st_nxt.cut_pos = wdata_i[WIN_START_LSB +: POS_W];
          st_nxt.sync_end = wdata_i[WIN_END_LSB +: POS_W];
        end
        REG_CUT_OFS: st_nxt.cut_ofs = wdata_i[POS_W-1:0];
        default: begin
          // route words handled above, status words read only
        end
      endcase
    end

    // register reads: data valid the cycle after the strobe only
    st_nxt.rdata = '0;
    if (rd_i) begin
      if (addr_i <= REG_ROUTE3 && addr_i[1:0] == 2'b00) begin
        for (int n = 0; n < SIG_PER_WORD; n++) begin
          st_nxt.rdata[n*ROUTE_W +: ROUTE_W] =
            st_r.route[32'(addr_i[3:2]) * SIG_PER_WORD + n];
        end
      end
      case (addr_i)
        REG_ALARM: st_nxt.rdata[POS_W-1:0] = st_r.alarm_lim;
        REG_HOME_WIN: st_nxt.rdata = {st_r.home_end, st_r.home_start};
        REG_MISS: st_nxt.rdata[MISS_W-1:0] = st_r.miss_lim;
        REG_LEN_FACTOR: st_nxt.rdata[POS_W-1:0] = st_r.len_factor;
        REG_CUT_TOL: st_nxt.rdata[POS_W-1:0] = st_r.cut_tol;
        REG_MASTER_ZERO: st_nxt.rdata[POS_W-1:0] = st_r.master_zero;
        REG_VIRT_ZERO: st_nxt.rdata[POS_W-1:0] = st_r.virt_zero;
        REG_REV_LIMIT: st_nxt.rdata[POS_W-1:0] = st_r.rev_lim;
        REG_MAX_CORR: st_nxt.rdata[POS_W-1:0] = st_r.max_corr;
        REG_THICK_WIN: st_nxt.rdata = {st_r.thick_end, st_r.thick_start};
        REG_CTRL: st_nxt.rdata[2:0] = st_r.ctrl;
        REG_CUT_WIN: st_nxt.rdata = {st_r.sync_end, st_r.cut_pos};
        REG_CUT_OFS: st_nxt.rdata[POS_W-1:0] = st_r.cut_ofs;
        REG_SIG_STAT: st_nxt.rdata = st_r.sig; // RULE_03
        REG_LINE_STAT: st_nxt.rdata[NUM_LINES-1:0] = st_r.lines;
        default: begin
          // unmapped and route words: zero or filled above
        end
      endcase
    end

    // printmark supervision per sheet
    if (mot_i.sheet_end) begin
      if (st_r.mark_seen) begin
        st_nxt.miss_cnt = '0;
      end else if (st_r.miss_cnt != '1) begin
        st_nxt.miss_cnt = st_r.miss_cnt + MISS_W'(1); // RULE_07
      end
      st_nxt.mark_seen = 1'b0;
    end
    // a mark landing with the sheet end still counts for the new sheet
    if (mot_i.mark_det && st_r.sig[SIG_MARK_WIN]) begin
      st_nxt.mark_seen = 1'b1;
    end

    // reverse travel monitor; clear input first, travel wins after it
    if (mot_i.clear_error) begin
      st_nxt.rev_dist = '0;
      st_nxt.rev_flag = 1'b0; // RULE_14
    end
    if (mot_i.line_step) begin
      if (!mot_i.line_fwd) begin
        if (st_nxt.rev_dist != '1) begin
          st_nxt.rev_dist = st_nxt.rev_dist + 17'h00001;
        end
        if (st_nxt.rev_dist > {1'b0, st_r.rev_lim}) begin
          st_nxt.rev_flag = 1'b1; // RULE_14
        end
      end else if (st_nxt.rev_dist != '0) begin
        st_nxt.rev_dist = st_nxt.rev_dist - 17'h00001;
        if (st_nxt.rev_dist == '0) begin
          st_nxt.rev_flag = 1'b0; // RULE_14
        end
      end
    end

    // waste cut judged at every completed cut
    if (mot_i.cut_done) begin
      st_nxt.waste = mot_i.test_cut ||
                     (mag(mot_i.cut_dev) > {1'b0, st_r.cut_tol}); // RULE_09
    end

    // teach result
    if (mot_i.teach) begin
      st_nxt.taught = mot_i.teach_ok; // RULE_16
    end

    // homing reference: invalidation first, completion wins
    if (mot_i.jog || !mot_i.ctrl_enable) begin
      st_nxt.homed = 1'b0; // RULE_17
    end
    if (mot_i.homing_done) begin
      st_nxt.homed = 1'b1; // RULE_17
    end

    // automatic run sequence
    case (st_r.run)
      RUN_IDLE: begin
        st_nxt.cut_seen = 1'b0;
        if (mot_i.start_stop) begin
          st_nxt.run = RUN_ON; // RULE_18
        end
      end
      RUN_ON: begin
        st_nxt.cut_seen = 1'b0;
        if (!mot_i.start_stop) begin
          st_nxt.run = RUN_STOP;
        end
      end
      RUN_STOP: begin
        // wait for the running cut to finish, then for standstill
        if (mot_i.cut_done) begin
          st_nxt.cut_seen = 1'b1;
        end
        if (mot_i.start_stop) begin
          st_nxt.run = RUN_ON;
        end else if ((st_r.cut_seen || mot_i.cut_done) && mot_i.still) begin
          st_nxt.run = RUN_IDLE; // RULE_18
        end
      end
      default: begin
        st_nxt.run = RUN_IDLE;
      end
    endcase

    // status vector
    s[SIG_READY] = mot_i.init_done && mot_i.selftest_ok; // RULE_04
    s[SIG_ALARM] = mag(mot_i.pos_err) > {1'b0, st_r.alarm_lim}; // RULE_05
    s[SIG_HOME] = in_win(mot_i.knife_pos, st_r.home_start,
                         st_r.home_end); // RULE_06
    s[SIG_NO_MARK] = (st_r.miss_lim != '0) &&
                     (st_r.miss_cnt >= st_r.miss_lim); // RULE_07
    s[SIG_LENGTH] = len_pulse; // RULE_08
    s[SIG_WASTE] = st_r.waste; // RULE_09
    s[SIG_ERROR] = mot_i.err_cond; // RULE_10
    s[SIG_MASTER_MOV] = mot_i.master_speed > st_r.master_zero; // RULE_11
    s[SIG_VIRT_MOV] = mot_i.virt_freq > st_r.virt_zero; // RULE_12
    s[SIG_MARK_WIN] = !st_r.ctrl[CTRL_MARK_WIN_EN] ||
                      mot_i.mark_win_open; // RULE_13
    s[SIG_REVERSE] = st_r.rev_flag; // RULE_14
    s[SIG_MAX_CORR] = mag(mot_i.corr_val) >= {1'b0, st_r.max_corr}; // RULE_15
    s[SIG_TAUGHT] = st_r.taught; // RULE_16
    s[SIG_HOMED] = st_r.homed; // RULE_17
    s[SIG_AUTO] = st_r.run != RUN_IDLE; // RULE_18
    s[SIG_THICK] = st_r.ctrl[CTRL_THICK_EN] &&
                   (in_win(mot_i.knife_pos, st_r.thick_start, st_r.thick_end)
                    ^ st_r.ctrl[CTRL_THICK_INV]); // RULE_19
    // pulse rises at the shifted cut position, falls past sync end
    cut_at = st_r.cut_pos + st_r.cut_ofs;
    s[SIG_VCUT] = in_win(mot_i.knife_pos, cut_at, st_r.sync_end); // RULE_20
    st_nxt.sig = s;

    // physical lines follow the registered status one cycle later
    st_nxt.lines = line_hit; // RULE_02
  end

  // state register with documented reset values
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.alarm_lim <= RST_CFG16;
      st_r.home_start <= RST_CFG16;
      st_r.home_end <= RST_CFG16;
      st_r.miss_lim <= RST_MISS;
      st_r.len_factor <= RST_LEN_FACTOR;
      st_r.ctrl <= RST_CTRL;
      st_r.run <= RUN_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign rdata_o = st_r.rdata;
  assign sig_o = st_r.sig; // RULE_03
  assign line_o = st_r.lines;

endmodule

// ==== verification/pulse_counter.sv ====
// remote counter model watching one output line
// assumes line_i is a registered line sampled on clk_i
`timescale 1ns/1ps
module pulse_counter (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // watched line
  input wire logic line_i,
  // rising edges, last high and low lengths
  output int edges_o,
  output int hi_o,
  output int lo_o
);
  int run; // cycles in level minus one
  logic last; // level at previous edge
  // count edges and time each level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edges_o <= 0;
      hi_o <= 0;
      lo_o <= 0;
      run <= 0;
      last <= 1'b0;
    end else if (line_i != last) begin
      if (last) hi_o <= run + 1;
      else lo_o <= run + 1;
      edges_o <= edges_o + int'(line_i);
      run <= 0;
      last <= line_i;
    end else begin
      run <= run + 1;
    end
  end
endmodule

// ==== verification/cutter_status_out_properties.sv ====
// port checker for the cutter status outputs
// assumes it is bound into cutter_status_out, one clock
`timescale 1ns/1ps
module cutter_status_out_chk
  import cutter_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // inputs of the block
  input wire motion_s mot_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  // outputs of the block
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [NUM_SIG-1:0] sig_o,
  input wire logic [NUM_LINES-1:0] line_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ready_follow_a: assert property ($past(rst_n_i) |-> sig_o[SIG_READY] ==
    ($past(mot_i.init_done) && $past(mot_i.selftest_ok))) else $error("ready wrong");
  error_follow_a: assert property ($past(rst_n_i) |->
    sig_o[SIG_ERROR] == $past(mot_i.err_cond)) else $error("error flag wrong");
  unused_zero_a: assert property ((sig_o & 32'hfff8_0240) == 32'h0)
    else $error("unused index active");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside answer cycle");
  stat_read_a: assert property ($past(rd_i) && $past(addr_i) == REG_SIG_STAT
    |-> rdata_o == $past(sig_o)) else $error("status read wrong");
  lines_dark_a: assert property ($past(rst_n_i) && $past(sig_o) == 32'h0
    |-> line_o == 8'h00) else $error("line high with no signal");
  auto_on_a: assert property (mot_i.start_stop ##1 mot_i.start_stop
    |-> ##1 sig_o[SIG_AUTO]) else $error("auto off while start on");
  len_step_a: assert property ($changed(sig_o[SIG_LENGTH]) |-> $past(mot_i.line_step) ||
    $past(mot_i.line_step, 2) || $past(mot_i.line_step, 3)) else $error("length edge no step");
  rev_clear_a: assert property (mot_i.clear_error && !mot_i.line_step
    |-> ##2 !sig_o[SIG_REVERSE]) else $error("reverse not cleared");
  // main scenarios reached
  rev_set_c: cover property (sig_o[SIG_REVERSE]);
  line_on_c: cover property (line_o != 8'h00);
  auto_end_c: cover property ($fell(sig_o[SIG_AUTO]));
endmodule
bind cutter_status_out cutter_status_out_chk i_cutter_status_out_chk (.clk_i, .rst_n_i,
  .mot_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sig_o, .line_o);

// ==== verification/cutter_status_out_tb.sv ====
// self-checking bench for the cutter status outputs
// assumes the checker binds itself and a counter watches line 0
`timescale 1ns/1ps
module cutter_status_out_tb
  import cutter_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  motion_s m = '0; // controller state driven here
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [NUM_SIG-1:0] sig;
  logic [NUM_LINES-1:0] line;
  logic [DATA_W-1:0] d; // last read word
  int edges;
  int hi;
  int lo;
  int error_cnt = 0;
  int compares = 0;
  cutter_status_out i_cutter_status_out (.clk_i, .rst_n_i, .mot_i(m), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sig_o(sig), .line_o(line));
  pulse_counter i_pulse_counter (.clk_i, .rst_n_i, .line_i(line[0]), .edges_o(edges),
    .hi_o(hi), .lo_o(lo));
  // 50 ns clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // let level and state updates land, sample mid-cycle
  task automatic settle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    v = rdata;
  endtask
  // evenly spaced travel steps, four cycles apart
  task automatic step(input logic fwd, input int n);
    repeat (n) begin
      @(posedge clk_i);
      m.line_step <= 1'b1;
      m.line_fwd <= fwd;
      @(posedge clk_i);
      m.line_step <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask
  // ready gating, status readback, mark window
  task automatic t_ready();
    @(posedge clk_i);
    m.init_done <= 1'b1;
    settle();
    chk(32'(sig[SIG_READY]), 32'h0);
    @(posedge clk_i);
    m.selftest_ok <= 1'b1;
    settle();
    chk(32'(sig[SIG_READY]), 32'h1);
    chk(32'(sig[SIG_MARK_WIN]), 32'h1);
    rd_reg(REG_SIG_STAT, d);
    chk(d & 32'h0000_0801, 32'h0000_0801);
    chk(d & 32'hfff8_0240, 32'h0);
    rd_reg(8'hfc, d);
    chk(d, 32'h0);
    wr_reg(REG_CTRL, 32'h1);
    settle();
    chk(32'(sig[SIG_MARK_WIN]), 32'h0);
    @(posedge clk_i);
    m.mark_win_open <= 1'b1;
    settle();
    chk(32'(sig[SIG_MARK_WIN]), 32'h1);
  endtask
  // alarm limit and home window boundaries
  task automatic t_win();
    logic [15:0] pe[4] = '{16'h0005, 16'h0006, 16'hfffa, 16'hfffb};
    logic [15:0] kp[4] = '{16'h0009, 16'h000a, 16'h0014, 16'h0015};
    logic [31:0] ex[4] = '{32'h0, 32'h1, 32'h1, 32'h0};
    wr_reg(REG_ALARM, 32'h5);
    wr_reg(REG_HOME_WIN, {16'h0014, 16'h000a});
    for (int i = 0; i < 4; i++) begin
      m.pos_err <= pe[i];
      m.knife_pos <= kp[i];
      settle();
      chk(32'(sig[SIG_ALARM]), ex[i]);
      chk(32'(sig[SIG_HOME]), ex[i]);
      @(posedge clk_i);
    end
  endtask
  // error signal walked across all eight lines
  task automatic t_route();
    m.err_cond <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr_reg(REG_ROUTE0, 32'(k + 1) << 28);
      settle();
      chk(32'(sig[SIG_ERROR]), 32'h1);
      chk(32'(line), 32'h1 << k);
    end
    @(posedge clk_i);
    m.err_cond <= 1'b0;
    settle();
    chk(32'(line), 32'h0);
  endtask
  // length pulses at factor two seen by the counter
  task automatic t_len();
    int e0;
    wr_reg(REG_ROUTE0, 32'h0001_0000);
    wr_reg(REG_LEN_FACTOR, 32'h2);
    e0 = edges;
    step(1'b1, 16);
    settle();
    chk(32'(edges - e0), 32'h4);
    chk(32'(hi), 32'(lo));
    chk(32'(hi), 32'h8);
  endtask
  // reverse limit, forward return, clear input
  task automatic t_rev();
    wr_reg(REG_REV_LIMIT, 32'h3);
    step(1'b0, 3);
    settle();
    chk(32'(sig[SIG_REVERSE]), 32'h0);
    step(1'b0, 1);
    settle();
    chk(32'(sig[SIG_REVERSE]), 32'h1);
    step(1'b1, 4);
    settle();
    chk(32'(sig[SIG_REVERSE]), 32'h0);
    step(1'b0, 4);
    settle();
    chk(32'(sig[SIG_REVERSE]), 32'h1);
    @(posedge clk_i);
    m.clear_error <= 1'b1;
    @(posedge clk_i);
    m.clear_error <= 1'b0;
    settle();
    chk(32'(sig[SIG_REVERSE]), 32'h0);
  endtask
  // automatic run holds until a cut at standstill
  task automatic t_auto();
    @(posedge clk_i);
    m.start_stop <= 1'b1;
    settle();
    chk(32'(sig[SIG_AUTO]), 32'h1);
    @(posedge clk_i);
    m.start_stop <= 1'b0;
    m.still <= 1'b1;
    settle();
    chk(32'(sig[SIG_AUTO]), 32'h1);
    @(posedge clk_i);
    m.cut_done <= 1'b1;
    @(posedge clk_i);
    m.cut_done <= 1'b0;
    settle();
    chk(32'(sig[SIG_AUTO]), 32'h0);
    chk(32'(sig[SIG_WASTE]), 32'h0);
  endtask
  // test cut waste, teach, homing and its loss, master motion
  task automatic t_flags();
    @(posedge clk_i);
    m.cut_done <= 1'b1;
    m.test_cut <= 1'b1;
    m.teach <= 1'b1;
    m.teach_ok <= 1'b1;
    m.homing_done <= 1'b1;
    m.ctrl_enable <= 1'b1;
    m.master_speed <= 16'h0001;
    @(posedge clk_i);
    m.cut_done <= 1'b0;
    m.teach <= 1'b0;
    m.homing_done <= 1'b0;
    settle();
    chk(32'(sig[SIG_WASTE]), 32'h1);
    chk(32'(sig[SIG_TAUGHT]), 32'h1);
    chk(32'(sig[SIG_HOMED]), 32'h1);
    chk(32'(sig[SIG_MASTER_MOV]), 32'h1);
    @(posedge clk_i);
    m.jog <= 1'b1;
    settle();
    chk(32'(sig[SIG_HOMED]), 32'h0);
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_ready();
    t_win();
    t_route();
    t_len();
    t_rev();
    t_auto();
    t_flags();
    give_verdict();
  end
endmodule
